//--- design/sarc_pkg.sv
// Purpose: Shared constants and types for the SAR converter control block
// Assumes: One core clock cycle stands for one oscillator cycle
// Notes:   Byte offsets on a 32-bit AXI4-Lite register bus
package sarc_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] SARC_OFF_CTRL1 = 8'h00;
    localparam logic [7:0] SARC_OFF_CTRL2 = 8'h04;
    localparam logic [7:0] SARC_OFF_RESU  = 8'h08;
    localparam logic [7:0] SARC_OFF_RESL  = 8'h0C;
    localparam logic [7:0] SARC_CTRL1_RST = 8'h0F;
    localparam logic [7:0] SARC_CTRL2_RST = 8'h10;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int SARC_START_BIT  = 7;
    localparam int SARC_MODE_HI    = 6;
    localparam int SARC_MODE_LO    = 5;
    localparam int SARC_INDIS_BIT  = 4;
    localparam int SARC_CH_HI      = 3;
    localparam int SARC_LADDER_BIT = 5;
    localparam int SARC_TIME_HI    = 3;
    localparam int SARC_TIME_LO    = 1;
    localparam int SARC_EOC_BIT    = 5;
    localparam int SARC_BUSY_BIT   = 4;
    // ****************************************
    // Modes and timing
    // ****************************************
    localparam logic [1:0]  SARC_MODE_OFF    = 2'h0;
    localparam logic [1:0]  SARC_MODE_SINGLE = 2'h1;
    localparam logic [1:0]  SARC_MODE_REPEAT = 2'h3;
    localparam logic [2:0]  SARC_HOLDOFF_CYC = 3'h4;
    localparam logic [10:0] SARC_CYC_39      = 11'h027;
    localparam logic [10:0] SARC_CYC_78      = 11'h04E;
    localparam logic [10:0] SARC_CYC_156     = 11'h09C;
    localparam logic [10:0] SARC_CYC_312     = 11'h138;
    localparam logic [10:0] SARC_CYC_624     = 11'h270;
    localparam logic [10:0] SARC_CYC_1248    = 11'h4E0;
    localparam logic [10:0] SARC_SAR_STEPS   = 11'h00A;
    localparam logic [10:0] SARC_SAMPLE_END  = 11'h00C;
    localparam logic [1:0]  SARC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  SARC_RESP_SLVERR = 2'h2;

    typedef enum logic {SARC_IDLE, SARC_CONV} sarc_state_t;

    typedef struct packed {
        logic       sample;
        logic       ladderOn;
        logic       inputDisable;
        logic [3:0] channel;
        logic [9:0] dacCode;
    } sarc_ana_t;
endpackage : sarc_pkg

//--- design/sarc_top.sv
// Purpose: Conversion control of a 10-bit SAR converter behind AXI4-Lite
// Assumes: Comparator input compHigh is high when input is above dacCode
// Notes:   Last ten cycles of a conversion resolve one bit each
// Functional notes
// - End flag reads 0 before or during conversion, 1 after; read only. In mode 11 it stays 1 through chained conversions until upper is read.
// - Busy flag rises when a conversion starts, falls when it finishes. In mode 11 it stays 1 while conversions chain.
// - Reading the upper result register clears the end flag.
// - Lower register bits 3 to 0 carry no meaning on read.
// - Mode 01 plus start bit runs one conversion of the chosen channel.
// - On completion store result, set end flag, pulse done interrupt together.
// - Start bit clears itself once its conversion has begun.
// - Mode 11 plus start repeats conversions back to back.
// - Writing mode 00 aborts at once; abandoned value is not stored.
// - New start clears end flag but keeps old result until completion.
// - Result is 10 bits: 2 LSBs low register, 8 MSBs upper.
// - Time codes pick 39 to 1248 cycles; 001 and 111 reserved.
// - Ladder bit 0 connects ladder only while converting, 1 always.
// - Start is ignored for four cycles after control one written zero.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
module sarc_top
    import sarc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        compHigh,
    output sarc_ana_t        anaOut,
    output logic             convDoneIrq
);
    // ****************************************
    // State
    // ****************************************
    logic        awHave_ff, nxt_awHave, wHave_ff, nxt_wHave;
    logic [7:0]  awAddr_ff, nxt_awAddr;
    logic [7:0]  wData_ff, nxt_wData;
    logic        wStrb_ff, nxt_wStrb;
    logic        bValid_ff, nxt_bValid, bErr_ff, nxt_bErr;
    logic        rValid_ff, nxt_rValid, rErr_ff, nxt_rErr;
    logic [7:0]  rData_ff, nxt_rData;
    logic [7:0]  ctrl1_ff, nxt_ctrl1, ctrl2_ff, nxt_ctrl2;
    logic [7:0]  resU_ff, nxt_resU;
    logic [1:0]  resL_ff, nxt_resL;
    logic        eoc_ff, nxt_eoc, busy_ff, nxt_busy, irq_ff, nxt_irq;
    logic [2:0]  hold_ff, nxt_hold;
    logic [10:0] cnt_ff, nxt_cnt, total_ff, nxt_total;
    logic [9:0]  dac_ff, nxt_dac;
    logic        smp_ff, nxt_smp;
    sarc_state_t state_ff, nxt_state;

    logic        wrFire, rdFire, wrCtrl1, abortReq, startFire, doneFire, chain;
    logic [10:0] selTotal, stepBase;
    logic [3:0]  bitIdx;

    // ****************************************
    // Conversion time table
    // ****************************************
    always_comb begin
        case (ctrl2_ff[SARC_TIME_HI:SARC_TIME_LO])
            3'h0:    selTotal = SARC_CYC_39;
            3'h2:    selTotal = SARC_CYC_78;
            3'h3:    selTotal = SARC_CYC_156;
            3'h4:    selTotal = SARC_CYC_312;
            3'h5:    selTotal = SARC_CYC_624;
            3'h6:    selTotal = SARC_CYC_1248;
            default: selTotal = SARC_CYC_1248;
        endcase
    end

    assign wrFire   = awHave_ff && wHave_ff && !bValid_ff;
    assign rdFire   = s_axi_arvalid && !rValid_ff;
    assign wrCtrl1  = wrFire && wStrb_ff && (awAddr_ff == SARC_OFF_CTRL1);
    assign abortReq = wrCtrl1 && (wData_ff[SARC_MODE_HI:SARC_MODE_LO] == SARC_MODE_OFF);
    assign stepBase = total_ff - SARC_SAR_STEPS;
    assign chain    = ctrl1_ff[SARC_MODE_HI:SARC_MODE_LO] == SARC_MODE_REPEAT;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        nxt_awHave = awHave_ff;
        nxt_wHave  = wHave_ff;
        nxt_awAddr = awAddr_ff;
        nxt_wData  = wData_ff;
        nxt_wStrb  = wStrb_ff;
        nxt_bValid = bValid_ff;
        nxt_bErr   = bErr_ff;
        nxt_rValid = rValid_ff;
        nxt_rErr   = rErr_ff;
        nxt_rData  = rData_ff;
        nxt_ctrl1  = ctrl1_ff;
        nxt_ctrl2  = ctrl2_ff;
        nxt_resU   = resU_ff;
        nxt_resL   = resL_ff;
        nxt_eoc    = eoc_ff;
        nxt_busy   = busy_ff;
        nxt_irq    = 1'b0;
        nxt_hold   = (hold_ff != 3'h0) ? hold_ff - 3'h1 : hold_ff;
        nxt_cnt    = cnt_ff;
        nxt_total  = total_ff;
        nxt_dac    = dac_ff;
        nxt_smp    = smp_ff;
        nxt_state  = state_ff;
        startFire  = 1'b0;
        doneFire   = 1'b0;
        bitIdx     = 4'h0;
        // Bus channel capture
        if (s_axi_awvalid && !awHave_ff) begin
            nxt_awHave = 1'b1;
            nxt_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHave_ff) begin
            nxt_wHave = 1'b1;
            nxt_wData = s_axi_wdata[7:0];
            nxt_wStrb = s_axi_wstrb[0];
        end
        if (bValid_ff && s_axi_bready) begin
            nxt_bValid = 1'b0;
        end
        if (rValid_ff && s_axi_rready) begin
            nxt_rValid = 1'b0;
        end
        if (rdFire) begin
            nxt_rValid = 1'b1;
            nxt_rErr   = 1'b0;
            case (s_axi_araddr)
                SARC_OFF_CTRL1: nxt_rData = ctrl1_ff;
                SARC_OFF_CTRL2: nxt_rData = {2'h0, ctrl2_ff[5:0]};
                SARC_OFF_RESU: begin
                    nxt_rData = resU_ff;
                    nxt_eoc   = 1'b0;
                end
                SARC_OFF_RESL: nxt_rData = {resL_ff, eoc_ff, busy_ff, 4'h0};
                default: begin
                    nxt_rData = 8'h00;
                    nxt_rErr  = 1'b1;
                end
            endcase
        end
        // Converter sequencing
        case (state_ff)
            SARC_IDLE: begin
                if (ctrl1_ff[SARC_START_BIT]) begin
                    nxt_ctrl1[SARC_START_BIT] = 1'b0;
                    if (hold_ff == 3'h0 &&
                        (ctrl1_ff[SARC_MODE_HI:SARC_MODE_LO] == SARC_MODE_SINGLE || chain)) begin
                        startFire = 1'b1;
                        nxt_state = SARC_CONV;
                        nxt_busy  = 1'b1;
                        nxt_eoc   = 1'b0;
                        nxt_cnt   = 11'h000;
                        nxt_total = selTotal;
                        nxt_smp   = 1'b1;
                        nxt_dac   = 10'h000;
                    end
                end
            end
            SARC_CONV: begin
                if (abortReq) begin
                    nxt_state = SARC_IDLE;
                    nxt_busy  = 1'b0;
                    nxt_smp   = 1'b0;
                end else begin
                    nxt_cnt = cnt_ff + 11'h001;
                    if (cnt_ff == total_ff - SARC_SAMPLE_END) begin
                        nxt_smp = 1'b0;
                    end
                    if (cnt_ff == stepBase - 11'h001) begin
                        nxt_dac = 10'h200;
                    end
                    if (cnt_ff >= stepBase) begin
                        bitIdx = 4'h9 - 4'(cnt_ff - stepBase);
                        nxt_dac[bitIdx] = compHigh;
                        if (bitIdx != 4'h0) begin
                            nxt_dac[bitIdx - 4'h1] = 1'b1;
                        end
                    end
                    if (cnt_ff == total_ff - 11'h001) begin
                        doneFire = 1'b1;
                        nxt_resU = nxt_dac[9:2];
                        nxt_resL = nxt_dac[1:0];
                        nxt_eoc  = 1'b1;
                        nxt_irq  = 1'b1;
                        if (chain) begin
                            nxt_cnt   = 11'h000;
                            nxt_total = selTotal;
                            nxt_smp   = 1'b1;
                        end else begin
                            nxt_state = SARC_IDLE;
                            nxt_busy  = 1'b0;
                        end
                    end
                end
            end
            default: nxt_state = SARC_IDLE;
        endcase
        // Register writes
        if (wrFire) begin
            nxt_awHave = 1'b0;
            nxt_wHave  = 1'b0;
            nxt_bValid = 1'b1;
            nxt_bErr   = 1'b0;
            case (awAddr_ff)
                SARC_OFF_CTRL1: if (wStrb_ff) begin
                    nxt_ctrl1 = wData_ff;
                    if (wData_ff == 8'h00) begin
                        nxt_hold = SARC_HOLDOFF_CYC;
                    end
                end
                SARC_OFF_CTRL2: if (wStrb_ff) begin
                    nxt_ctrl2 = wData_ff;
                end
                SARC_OFF_RESU, SARC_OFF_RESL: nxt_bErr = 1'b0;
                default: nxt_bErr = 1'b1;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            awHave_ff <= 1'b0;
            wHave_ff  <= 1'b0;
            awAddr_ff <= 8'h00;
            wData_ff  <= 8'h00;
            wStrb_ff  <= 1'b0;
            bValid_ff <= 1'b0;
            bErr_ff   <= 1'b0;
            rValid_ff <= 1'b0;
            rErr_ff   <= 1'b0;
            rData_ff  <= 8'h00;
            ctrl1_ff  <= SARC_CTRL1_RST;
            ctrl2_ff  <= SARC_CTRL2_RST;
            resU_ff   <= 8'h00;
            resL_ff   <= 2'h0;
            eoc_ff    <= 1'b0;
            busy_ff   <= 1'b0;
            irq_ff    <= 1'b0;
            hold_ff   <= 3'h0;
            cnt_ff    <= 11'h000;
            total_ff  <= SARC_CYC_39;
            dac_ff    <= 10'h000;
            smp_ff    <= 1'b0;
            state_ff  <= SARC_IDLE;
        end else begin
            awHave_ff <= nxt_awHave;
            wHave_ff  <= nxt_wHave;
            awAddr_ff <= nxt_awAddr;
            wData_ff  <= nxt_wData;
            wStrb_ff  <= nxt_wStrb;
            bValid_ff <= nxt_bValid;
            bErr_ff   <= nxt_bErr;
            rValid_ff <= nxt_rValid;
            rErr_ff   <= nxt_rErr;
            rData_ff  <= nxt_rData;
            ctrl1_ff  <= nxt_ctrl1;
            ctrl2_ff  <= nxt_ctrl2;
            resU_ff   <= nxt_resU;
            resL_ff   <= nxt_resL;
            eoc_ff    <= nxt_eoc;
            busy_ff   <= nxt_busy;
            irq_ff    <= nxt_irq;
            hold_ff   <= nxt_hold;
            cnt_ff    <= nxt_cnt;
            total_ff  <= nxt_total;
            dac_ff    <= nxt_dac;
            smp_ff    <= nxt_smp;
            state_ff  <= nxt_state;
        end
    end

    assign s_axi_awready = !awHave_ff;
    assign s_axi_wready  = !wHave_ff;
    assign s_axi_bvalid  = bValid_ff;
    assign s_axi_bresp   = bErr_ff ? SARC_RESP_SLVERR : SARC_RESP_OKAY;
    assign s_axi_arready = !rValid_ff;
    assign s_axi_rvalid  = rValid_ff;
    assign s_axi_rresp   = rErr_ff ? SARC_RESP_SLVERR : SARC_RESP_OKAY;
    assign s_axi_rdata   = {24'h000000, rData_ff};
    assign convDoneIrq   = irq_ff;
    assign anaOut = '{sample: smp_ff, ladderOn: ctrl2_ff[SARC_LADDER_BIT] | busy_ff,
                      inputDisable: ctrl1_ff[SARC_INDIS_BIT],
                      channel: ctrl1_ff[SARC_CH_HI:0], dacCode: dac_ff};

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_start;
        startFire ##1 busy_ff;
    endsequence
    sequence s_done;
        doneFire ##1 (eoc_ff && irq_ff);
    endsequence
    property p_busy_start;
        @(posedge core_clk) disable iff (!reset_n) startFire |-> s_start;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not set");
    property p_start_clr;
        @(posedge core_clk) disable iff (!reset_n)
            startFire && !wrCtrl1 |=> !ctrl1_ff[SARC_START_BIT];
    endproperty
    a_start_clr: assert property (p_start_clr) else $error("start bit stuck");
    property p_done;
        @(posedge core_clk) disable iff (!reset_n)
            doneFire |-> s_done ##0 (resU_ff == $past(dac_ff[9:2]));
    endproperty
    a_done: assert property (p_done) else $error("done effects missing");
    property p_upper_clr;
        @(posedge core_clk) disable iff (!reset_n)
            rdFire && s_axi_araddr == SARC_OFF_RESU && !doneFire |=> !eoc_ff;
    endproperty
    a_upper_clr: assert property (p_upper_clr) else $error("flag not cleared");
    property p_abort;
        @(posedge core_clk) disable iff (!reset_n)
            state_ff == SARC_CONV && abortReq |=> !busy_ff && $stable(resU_ff) && !irq_ff;
    endproperty
    a_abort: assert property (p_abort) else $error("abort failed");
    property p_keep;
        @(posedge core_clk) disable iff (!reset_n)
            startFire |=> !eoc_ff && $stable(resU_ff);
    endproperty
    a_keep: assert property (p_keep) else $error("result lost on start");
    property p_holdoff;
        @(posedge core_clk) disable iff (!reset_n)
            wrCtrl1 && wData_ff == 8'h00 |=> (!startFire) [*4];
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("start in holdoff");
    property p_timing;
        @(posedge core_clk) disable iff (!reset_n)
            state_ff == SARC_CONV && !abortReq && cnt_ff != total_ff - 11'h001
                |=> cnt_ff == $past(cnt_ff) + 11'h001 && total_ff == $past(total_ff);
    endproperty
    a_timing: assert property (p_timing) else $error("bad conversion length");
    property p_repeat;
        @(posedge core_clk) disable iff (!reset_n)
            doneFire && chain |=> busy_ff && cnt_ff == 11'h000;
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat not chained");
endmodule : sarc_top

//--- test/sarc_analog_model.sv
// Purpose: Comparator and ladder stand-in for the converter's analog side
// Assumes: level is the input as a code, sitting half a step above it
// Notes:   Without the ladder the comparator output is meaningless noise
module sarc_analog_model
    import sarc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire sarc_ana_t  anaOut,
    input  wire logic [9:0] level,
    output logic            compHigh
);
    timeunit 1ns;
    timeprecision 1ps;

    logic noise_ff = 1'b0;

    always_ff @(posedge core_clk) begin
        noise_ff <= ~noise_ff;
    end

    always_comb begin
        compHigh = anaOut.ladderOn ? (level >= anaOut.dacCode) : noise_ff;
    end
endmodule : sarc_analog_model

//--- test/sarc_top_tb.sv
// Purpose: Self-checking bench of the converter control over AXI4-Lite
// Assumes: Analog side is the behavioural comparator model
// Notes:   Irq monitor measures cycles from last write response to done
`define SARC_CHK(g, e) chk(32'(g), 32'(e))
module sarc_top_tb
    import sarc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk      = 1'b0;
    logic        reset_n       = 1'b0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_bready  = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready  = 1'b0;
    logic [9:0]  level         = 10'h000;
    logic        bLast         = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        compHigh, convDoneIrq;
    sarc_ana_t   anaOut;
    logic [7:0]  rd;
    int          nFail = 0, nCompared = 0, cyc = 0, wStamp = 0, gap = 0, irqs = 0;

    sarc_top u_dut (
        .core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compHigh, .anaOut, .convDoneIrq
    );

    sarc_analog_model u_ana (.core_clk, .anaOut, .level, .compHigh);

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    // ****************************************
    // Monitor and bus tasks
    // ****************************************
    always @(posedge core_clk) begin
        cyc++;
        if (s_axi_bvalid && !bLast) wStamp = cyc;
        bLast = s_axi_bvalid;
        if (convDoneIrq === 1'b1) begin
            irqs++;
            gap = cyc - wStamp;
        end
    end

    function automatic void chk(input logic [31:0] g, input logic [31:0] e);
        nCompared++;
        if (g !== e) begin
            nFail++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endfunction : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        `SARC_CHK(s_axi_bvalid, 1'b1);
        `SARC_CHK(s_axi_bresp, er);
    endtask : wr

    task automatic rdReg(input logic [7:0] a, input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata[7:0];
        `SARC_CHK(s_axi_rvalid, 1'b1);
        `SARC_CHK(s_axi_rresp, er);
    endtask : rdReg

    task automatic waitIrq(input int n0);
        for (int n = 0; n < 3000 && irqs <= n0; n++) @(posedge core_clk);
        `SARC_CHK(irqs > n0, 1'b1);
    endtask : waitIrq

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic tReset();
        rdReg(SARC_OFF_CTRL1, SARC_RESP_OKAY);
        `SARC_CHK(rd, SARC_CTRL1_RST);
        rdReg(SARC_OFF_CTRL2, SARC_RESP_OKAY);
        `SARC_CHK(rd, SARC_CTRL2_RST);
        rdReg(SARC_OFF_RESL, SARC_RESP_OKAY);
        `SARC_CHK(rd[5:4], 2'h0);
        `SARC_CHK({convDoneIrq, anaOut.ladderOn, anaOut.sample, anaOut.inputDisable}, 4'h0);
        rdReg(8'h10, SARC_RESP_SLVERR);
        `SARC_CHK(rd, 8'h00);
        wr(SARC_OFF_CTRL1, 8'hA1, 4'h0, SARC_RESP_OKAY);
        wr(8'h10, 8'hFF, 4'hF, SARC_RESP_SLVERR);
        rdReg(SARC_OFF_RESL, SARC_RESP_OKAY);
        `SARC_CHK(rd[4], 1'b0);
        $display("test reset done");
    endtask : tReset

    task automatic tSingle();
        int n0;
        level <= 10'h2B6;
        wr(SARC_OFF_CTRL2, 8'h10, 4'hF, SARC_RESP_OKAY);
        wr(SARC_OFF_CTRL1, 8'h21, 4'hF, SARC_RESP_OKAY);
        wr(SARC_OFF_CTRL1, 8'hA1, 4'hF, SARC_RESP_OKAY);
        n0 = irqs;
        rdReg(SARC_OFF_RESL, SARC_RESP_OKAY);
        `SARC_CHK(rd[5:4], 2'h1);
        `SARC_CHK({anaOut.sample, anaOut.ladderOn, anaOut.channel}, 6'h31);
        rdReg(SARC_OFF_CTRL1, SARC_RESP_OKAY);
        `SARC_CHK(rd, 8'h21);
        waitIrq(n0);
        `SARC_CHK(gap, 40);
        repeat (4) @(posedge core_clk);
        `SARC_CHK(irqs, n0 + 1);
        rdReg(SARC_OFF_RESL, SARC_RESP_OKAY);
        `SARC_CHK(rd[7:4], {level[1:0], 2'h2});
        rdReg(SARC_OFF_RESU, SARC_RESP_OKAY);
        `SARC_CHK(rd, level[9:2]);
        rdReg(SARC_OFF_RESL, SARC_RESP_OKAY);
        `SARC_CHK(rd[5:4], 2'h0);
        `SARC_CHK({anaOut.sample, anaOut.ladderOn}, 2'h0);
        $display("test single done");
    endtask : tSingle

    task automatic tTimes();
        logic [2:0]  codes [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
        logic [10:0] tab   [6] = '{SARC_CYC_39, SARC_CYC_78, SARC_CYC_156,
                                   SARC_CYC_312, SARC_CYC_624, SARC_CYC_1248};
        for (int i = 0; i < 6; i++) begin
            wr(SARC_OFF_CTRL2, {4'h1, codes[i], 1'b0}, 4'hF, SARC_RESP_OKAY);
            wr(SARC_OFF_CTRL1, 8'hA1, 4'hF, SARC_RESP_OKAY);
            waitIrq(irqs);
            `SARC_CHK(gap, tab[i] + 11'h001);
        end
        $display("test times done");
    endtask : tTimes

    task automatic tKeep();
        logic [7:0] old;
        old   = level[9:2];
        level <= 10'h15A;
        wr(SARC_OFF_CTRL2, 8'h30, 4'hF, SARC_RESP_OKAY);
        wr(SARC_OFF_CTRL1, 8'hA1, 4'hF, SARC_RESP_OKAY);
        rdReg(SARC_OFF_RESL, SARC_RESP_OKAY);
        `SARC_CHK(rd[5:4], 2'h1);
        rdReg(SARC_OFF_RESU, SARC_RESP_OKAY);
        `SARC_CHK(rd, old);
        waitIrq(irqs);
        `SARC_CHK(anaOut.ladderOn, 1'b1);
        rdReg(SARC_OFF_RESU, SARC_RESP_OKAY);
        `SARC_CHK(rd, level[9:2]);
        $display("test keep done");
    endtask : tKeep

    task automatic tRepeat();
        int n1;
        level <= 10'h3C5;
        wr(SARC_OFF_CTRL2, 8'h10, 4'hF, SARC_RESP_OKAY);
        wr(SARC_OFF_CTRL1, 8'hE2, 4'hF, SARC_RESP_OKAY);
        waitIrq(irqs + 1);
        `SARC_CHK(anaOut.channel, 4'h2);
        rdReg(SARC_OFF_RESL, SARC_RESP_OKAY);
        `SARC_CHK(rd[5:4], 2'h3);
        level <= 10'h111;
        wr(SARC_OFF_CTRL1, 8'h12, 4'hF, SARC_RESP_OKAY);
        n1 = irqs;
        repeat (100) @(posedge core_clk);
        `SARC_CHK(irqs, n1);
        `SARC_CHK(anaOut.inputDisable, 1'b1);
        rdReg(SARC_OFF_RESU, SARC_RESP_OKAY);
        `SARC_CHK(rd, 8'hF1);
        rdReg(SARC_OFF_RESL, SARC_RESP_OKAY);
        `SARC_CHK(rd[4], 1'b0);
        $display("test repeat done");
    endtask : tRepeat

    task automatic tHoldoff();
        int n0;
        wr(SARC_OFF_CTRL1, 8'h00, 4'hF, SARC_RESP_OKAY);
        wr(SARC_OFF_CTRL1, 8'hA1, 4'hF, SARC_RESP_OKAY);
        n0 = irqs;
        repeat (60) @(posedge core_clk);
        `SARC_CHK(irqs, n0);
        rdReg(SARC_OFF_CTRL1, SARC_RESP_OKAY);
        `SARC_CHK(rd, 8'h21);
        wr(SARC_OFF_CTRL1, 8'hC1, 4'hF, SARC_RESP_OKAY);
        repeat (60) @(posedge core_clk);
        `SARC_CHK(irqs, n0);
        rdReg(SARC_OFF_CTRL1, SARC_RESP_OKAY);
        `SARC_CHK(rd, 8'h41);
        wr(SARC_OFF_CTRL1, 8'hA1, 4'hF, SARC_RESP_OKAY);
        waitIrq(n0);
        $display("test holdoff done");
    endtask : tHoldoff

    task automatic results();
        $display("compared %0d mismatches %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results

    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        tReset();
        tSingle();
        tTimes();
        tKeep();
        tRepeat();
        tHoldoff();
        results();
    end

    initial begin
        #(4 * 20000);
        nFail++;
        results();
    end
endmodule : sarc_top_tb
